// ---- design/cscd_regs.vh ----
`ifndef CSCD_REGS_VH
`define CSCD_REGS_VH

// register indices; byte address is four times the index
`define CSCD_IDX_GEN_CFG 6'h1A
`define CSCD_IDX_SCAN_CFG 6'h1B
`define CSCD_IDX_SOFT_RST 6'h1C
`define CSCD_IDX_DRV0 6'h1E
`define CSCD_IDX_DRV1 6'h1F
`define CSCD_IDX_DRV2 6'h20

// field positions
`define CSCD_SEL_HI 15
`define CSCD_SEL_LO 14
`define CSCD_OVR_BIT 12
`define CSCD_AMPDIS_BIT 10
`define CSCD_SCAN_EN_BIT 15
`define CSCD_ORDER_HI 14
`define CSCD_ORDER_LO 13
`define CSCD_DEGL_HI 2
`define CSCD_DEGL_LO 0
`define CSCD_SOFT_RST_BIT 15
`define CSCD_PROG_HI 15
`define CSCD_PROG_LO 11
`define CSCD_CAL_HI 10
`define CSCD_CAL_LO 6

// reset values
`define CSCD_GEN_CFG_RST 16'h2801
`define CSCD_SCAN_CFG_RST 16'h020F
`define CSCD_SOFT_RESV_RST 15'h0000
`define CSCD_DRV_RST 5'h00

// scan order codes
`define CSCD_ORDER_01 2'h0
`define CSCD_ORDER_012 2'h1
`define CSCD_ORDER_0123 2'h2
`define CSCD_ORDER_01B 2'h3

// deglitch bandwidth codes
`define CSCD_DEGL_1M 3'h1
`define CSCD_DEGL_3M3 3'h4
`define CSCD_DEGL_10M 3'h5
`define CSCD_DEGL_33M 3'h7

// bus responses
`define CSCD_RESP_OKAY 2'h0
`define CSCD_RESP_SLVERR 2'h2
`endif

// ---- design/cscd_seq.v ----
`timescale 1ns/1ps
`include "cscd_regs.vh"
module cscd_seq (
	input wire aclk,
	input wire rst_n,
	input wire ce,
	input wire scan_en,
	input wire [1:0] order,
	input wire [1:0] single_sel,
	input wire conv_done,
	output reg [1:0] single_channel_select,
	output reg scan_wrap
);
	localparam ST_SINGLE = 1'b0; // one channel, continuous
	localparam ST_SCAN = 1'b1; // auto-scan over a list

	reg state; // sequencer state
	reg [1:0] last_chan; // final channel of the chosen list

	// list length from the order code
	always @* begin
		case (order)
			`CSCD_ORDER_01: last_chan = 2'h1;
			`CSCD_ORDER_012: last_chan = 2'h2;
			`CSCD_ORDER_0123: last_chan = 2'h3;
			default: last_chan = 2'h1;
		endcase
	end

	// channel stepping
	always @(posedge aclk) begin
		if (!rst_n) begin
			state <= ST_SINGLE;
			single_channel_select <= 2'h0;
			scan_wrap <= 1'b0;
		end else if (ce) begin
			scan_wrap <= 1'b0;
			case (state)
				ST_SINGLE: begin
					// follows the select field live, no conversion boundary needed
					single_channel_select <= single_sel;
					if (scan_en) begin
						state <= ST_SCAN;
						single_channel_select <= 2'h0;
					end
				end
				ST_SCAN: begin
					if (!scan_en) begin
						state <= ST_SINGLE;
						single_channel_select <= single_sel;
					end else if (single_channel_select > last_chan) begin
						// list shortened under us: restart rather than run off the end
						single_channel_select <= 2'h0;
					end else if (conv_done) begin
						if (single_channel_select == last_chan) begin
							single_channel_select <= 2'h0;
							scan_wrap <= 1'b1;
						end else begin
							single_channel_select <= single_channel_select + 2'h1;
						end
					end
				end
				default: state <= ST_SINGLE;
			endcase
		end
	end
endmodule // cscd_seq

// ---- design/cscd_drv.v ----
`timescale 1ns/1ps
`include "cscd_regs.vh"
module cscd_drv (
	input wire aclk,
	input wire rst_n,
	input wire ce,
	input wire cal_init_valid,
	input wire amp_corr_valid,
	input wire [1:0] cal_chan,
	input wire [4:0] cal_level,
	input wire amp_track_dis,
	output wire [14:0] cal_levels
);
	genvar i;
	// one calibrated level per channel with a register here (0 to 2)
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_cal
			reg [4:0] level; // calibrated drive level
			wire hit; // calibration result aimed at this channel
			assign hit = (cal_chan == i[1:0]);
			always @(posedge aclk) begin
				if (!rst_n) begin
					level <= `CSCD_DRV_RST;
				end else if (ce && hit) begin
					// initial calibration always lands; later corrections only while tracking
					if (cal_init_valid) begin
						level <= cal_level;
					end else if (amp_corr_valid && !amp_track_dis) begin
						level <= cal_level;
					end
				end
			end
			assign cal_levels[i*5 +: 5] = level;
		end
	endgenerate
endmodule // cscd_drv

// ---- design/cscd_top.v ----
`timescale 1ns/1ps
`include "cscd_regs.vh"
module cscd_top (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	// axi4-lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// conversion core and calibration
	input wire conv_done,
	input wire cal_init_valid,
	input wire amp_corr_valid,
	input wire [1:0] cal_chan,
	input wire [4:0] cal_level,
	output wire [1:0] single_channel_select,
	output wire scan_wrap,
	output reg [4:0] drive_level,
	output reg drive_override,
	output reg amp_correction_enable,
	output reg [3:0] deglitch_bw,
	output reg soft_reset_pulse
);
	// overview:
	// - six 16-bit words behind the lite slave, one per word index
	// - the sequencer picks the converting channel
	// - the drive store keeps calibration results per channel
	// - outputs to the analog side are registered, never glitching

	// word map:
	// - general word: channel select, override, tracking disable
	// - scan word: scan enable, list code, filter code
	// - soft reset word: top bit starts a reset, the rest is scratch
	// - drive words, channels 0 to 2: programmed and calibrated levels

	// reset and enable:
	// - aresetn clears the whole block, bus included
	// - a soft reset clears words, levels and sequencer, not the bus
	// - ce low freezes every flop; resets still act at any edge

	// limitations:
	// - channel 3 has no drive word here; its level reads zero
	// - only byte lanes 0 and 1 matter; the upper half is dropped
	// - one read may be in flight at a time; a second write can be taken into the slots while a response waits

	// write channel holding state
	reg aw_held; // address waiting for its data
	reg w_held; // data waiting for its address
	reg [5:0] wr_idx; // word index of pending write
	reg [15:0] wr_data; // low half of pending write data
	reg [1:0] wr_strb; // byte lanes of pending write
	// handshake terms
	wire aw_hs; // address taken this edge
	wire w_hs; // data taken this edge
	wire ar_hs; // read address taken this edge
	wire do_write; // both halves present, response slot free
	wire next_aw_held;
	wire next_w_held;

	// configuration storage
	reg [15:0] gen_cfg; // general configuration word
	reg [15:0] scan_cfg; // scan configuration word
	reg [14:0] soft_resv; // reserved bits of soft reset word
	reg soft_rst_q; // one-cycle soft reset strobe
	wire cfg_rst_n; // power-on or soft reset, active low
	wire [14:0] prog_levels; // programmed levels, channels 0..2
	wire [14:0] cal_levels; // calibrated levels, channels 0..2

	// decode helpers
	reg wr_hit; // pending write index is mapped
	reg rd_hit; // read index is mapped
	reg [15:0] rd_word; // read mux result
	reg [4:0] sel_prog; // programmed level of active channel
	reg [4:0] sel_cal; // calibrated level of active channel
	wire [5:0] rd_idx;

	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign next_aw_held = (aw_held || aw_hs) && !do_write;
	assign next_w_held = (w_held || w_hs) && !do_write;
	assign rd_idx = s_axi_araddr[7:2];
	// a soft reset clears the configuration but never the bus handshake
	assign cfg_rst_n = aresetn && !soft_rst_q;

	// byte-lane merge for the 16-bit registers
	// merging works on the stored value, so a one-lane write
	// never disturbs the other half of a register
	function [15:0] lane_merge;
		input [15:0] old_val;
		input [15:0] new_val;
		input [1:0] strb;
		begin
			lane_merge[7:0] = strb[0] ? new_val[7:0] : old_val[7:0];
			lane_merge[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
		end
	endfunction

	// write decode of the held index
	// decoded from the held index so the response code is ready with bvalid
	always @* begin
		case (wr_idx)
			`CSCD_IDX_GEN_CFG, `CSCD_IDX_SCAN_CFG, `CSCD_IDX_SOFT_RST,
			`CSCD_IDX_DRV0, `CSCD_IDX_DRV1, `CSCD_IDX_DRV2: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// write timing: the edge that takes the later half fills both slots,
	// the next edge commits the word and raises the response;
	// while a response waits for bready no word is committed,
	// so the full slots hold the master off instead of losing data;
	// an unmapped index still completes, with a slave error and no store
	// write channel: address and data accepted in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_idx <= 6'h00;
			wr_data <= 16'h0000;
			wr_strb <= 2'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CSCD_RESP_OKAY;
		end else if (ce) begin
			if (aw_hs) begin
				wr_idx <= s_axi_awaddr[7:2];
			end
			if (w_hs) begin
				wr_data <= s_axi_wdata[15:0];
				wr_strb <= s_axi_wstrb[1:0];
			end
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			// ready only while the matching holding slot is empty
			s_axi_awready <= !next_aw_held;
			s_axi_wready <= !next_w_held;
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `CSCD_RESP_OKAY : `CSCD_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// soft reset strobe, kept out of the config reset so it lasts exactly a cycle
	// the strobe clears the configuration one edge after the write commits,
	// so the response of the reset write is already standing
	// and survives, since the bus is outside the soft reset
	// a second reset write during the strobe just repeats the reset
	always @(posedge aclk) begin
		if (!aresetn) begin
			soft_rst_q <= 1'b0;
			soft_reset_pulse <= 1'b0;
		end else if (ce) begin
			soft_rst_q <= do_write && (wr_idx == `CSCD_IDX_SOFT_RST) &&
				wr_strb[1] && wr_data[`CSCD_SOFT_RST_BIT];
			soft_reset_pulse <= soft_rst_q;
		end
	end

	// general, scan and soft reset words
	// the three words share one reset; lanes not strobed keep their value
	// the soft reset word keeps its reserved bits but never its top bit
	always @(posedge aclk) begin
		if (!cfg_rst_n) begin
			gen_cfg <= `CSCD_GEN_CFG_RST;
			scan_cfg <= `CSCD_SCAN_CFG_RST;
			soft_resv <= `CSCD_SOFT_RESV_RST;
		end else if (ce && do_write) begin
			case (wr_idx)
				`CSCD_IDX_GEN_CFG: gen_cfg <= lane_merge(gen_cfg, wr_data, wr_strb);
				// reserved scan bits are stored as written; software keeps them at 0x041
				`CSCD_IDX_SCAN_CFG: scan_cfg <= lane_merge(scan_cfg, wr_data, wr_strb);
				`CSCD_IDX_SOFT_RST: begin
					if (wr_strb[0]) begin
						soft_resv[7:0] <= wr_data[7:0];
					end
					if (wr_strb[1]) begin
						soft_resv[14:8] <= wr_data[14:8];
					end
				end
				default: soft_resv <= soft_resv;
			endcase
		end
	end

	// programmed drive levels, one per channel
	// the programmed field sits in the upper lane only, so lane 0 writes skip it
	// the calibrated half of the word is read-only and ignored on writes
	genvar c;
	generate
		for (c = 0; c < 3; c = c + 1) begin : g_prog
			reg [4:0] level; // programmed drive level
			always @(posedge aclk) begin
				if (!cfg_rst_n) begin
					level <= `CSCD_DRV_RST;
				end else if (ce && do_write && wr_strb[1] && wr_idx == (`CSCD_IDX_DRV0 + c)) begin
					level <= wr_data[`CSCD_PROG_HI:`CSCD_PROG_LO];
				end
			end
			assign prog_levels[c*5 +: 5] = level;
		end
	endgenerate

	// read mux; general, scan and soft reset reserved bits read as stored; the soft reset top bit, drive low bits and unmapped bits read zero
	// the word is taken when the address is accepted, so a calibration
	// result landing at that same edge shows on the next read only
	// an unmapped index reads zero with a slave error
	always @* begin
		rd_hit = 1'b1;
		rd_word = 16'h0000;
		case (rd_idx)
			`CSCD_IDX_GEN_CFG: rd_word = gen_cfg;
			`CSCD_IDX_SCAN_CFG: rd_word = scan_cfg;
			`CSCD_IDX_SOFT_RST: rd_word = {1'b0, soft_resv};
			`CSCD_IDX_DRV0: rd_word = {prog_levels[4:0], cal_levels[4:0], 6'h00};
			`CSCD_IDX_DRV1: rd_word = {prog_levels[9:5], cal_levels[9:5], 6'h00};
			`CSCD_IDX_DRV2: rd_word = {prog_levels[14:10], cal_levels[14:10], 6'h00};
			default: rd_hit = 1'b0;
		endcase
	end

	// read channel: one read outstanding, address blocked until data taken
	// arready drops at the edge that takes an address, rvalid rises there;
	// arready returns at the edge that takes the data, one read at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CSCD_RESP_OKAY;
		end else if (ce) begin
			if (ar_hs) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {16'h0000, rd_word};
				s_axi_rresp <= rd_hit ? `CSCD_RESP_OKAY : `CSCD_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// channel sequencer
	// restarts with the configuration on a soft reset; its controls come
	// straight from the stored words
	cscd_seq u_seq (
		.aclk(aclk),
		.rst_n(cfg_rst_n),
		.ce(ce),
		.scan_en(scan_cfg[`CSCD_SCAN_EN_BIT]),
		.order(scan_cfg[`CSCD_ORDER_HI:`CSCD_ORDER_LO]),
		.single_sel(gen_cfg[`CSCD_SEL_HI:`CSCD_SEL_LO]),
		.conv_done(conv_done),
		.single_channel_select(single_channel_select),
		.scan_wrap(scan_wrap)
	);

	// calibrated level store
	// tracking disable gates corrections only; an initial result always lands
	cscd_drv u_drv (
		.aclk(aclk),
		.rst_n(cfg_rst_n),
		.ce(ce),
		.cal_init_valid(cal_init_valid),
		.amp_corr_valid(amp_corr_valid),
		.cal_chan(cal_chan),
		.cal_level(cal_level),
		.amp_track_dis(gen_cfg[`CSCD_AMPDIS_BIT]),
		.cal_levels(cal_levels)
	);

	// levels of the active channel; channel 3 fields live elsewhere and read zero here
	// combinational, but it only feeds the registered drive level,
	// so a channel change reaches the analog side one edge later
	// the programmed level counts only while override is set
	always @* begin
		case (single_channel_select)
			2'h0: begin
				sel_prog = prog_levels[4:0];
				sel_cal = cal_levels[4:0];
			end
			2'h1: begin
				sel_prog = prog_levels[9:5];
				sel_cal = cal_levels[9:5];
			end
			2'h2: begin
				sel_prog = prog_levels[14:10];
				sel_cal = cal_levels[14:10];
			end
			default: begin
				sel_prog = 5'h00;
				sel_cal = 5'h00;
			end
		endcase
	end

	// drive and filter outputs, registered one cycle behind the configuration
	// every output resets to what the reset configuration produces,
	// so the first enabled edge after a reset changes nothing
	// undefined filter codes are stored as written and only map to 33 MHz here
	always @(posedge aclk) begin
		if (!cfg_rst_n) begin
			drive_level <= `CSCD_DRV_RST;
			drive_override <= 1'b0;
			amp_correction_enable <= 1'b1;
			deglitch_bw <= 4'h8;
		end else if (ce) begin
			drive_override <= gen_cfg[`CSCD_OVR_BIT];
			// programmed level only counts with override on; else calibration owns the drive
			drive_level <= gen_cfg[`CSCD_OVR_BIT] ? sel_prog : sel_cal;
			amp_correction_enable <= !gen_cfg[`CSCD_AMPDIS_BIT];
			// undefined codes fall back to the widest filter so no edges are lost
			case (scan_cfg[`CSCD_DEGL_HI:`CSCD_DEGL_LO])
				`CSCD_DEGL_1M: deglitch_bw <= 4'h1;
				`CSCD_DEGL_3M3: deglitch_bw <= 4'h2;
				`CSCD_DEGL_10M: deglitch_bw <= 4'h4;
				default: deglitch_bw <= 4'h8;
			endcase
		end
	end
endmodule // cscd_top

// ---- verif/cscd_top_chk.sv ----
`timescale 1ns/1ps
`include "cscd_regs.vh"
// watches the bus handshakes and the drive outputs of the top
module cscd_chk (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] single_channel_select,
	input wire scan_wrap,
	input wire [4:0] drive_level,
	input wire drive_override,
	input wire amp_correction_enable,
	input wire [3:0] deglitch_bw,
	input wire soft_reset_pulse
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// both halves of a write taken at one edge
	wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_WR_ANSWER: assert property (wr_take |=> ##[0:1] s_axi_bvalid)
		else $error("write response late");
	AST_AW_LOCK: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second address taken during write");
	AST_RDATA_HIGH: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	AST_WRAP_ZERO: assert property (scan_wrap |-> single_channel_select == 2'h0)
		else $error("list restart not at channel 0");
	AST_BW_ONEHOT: assert property ($onehot(deglitch_bw))
		else $error("bandwidth select not one-hot");
	AST_SOFT_PULSE: assert property (wr_take && s_axi_awaddr[7:2] == `CSCD_IDX_SOFT_RST && s_axi_wstrb[1]
		&& s_axi_wdata[15] |-> ##[3:5] soft_reset_pulse) else $error("soft reset missing");
	AST_SOFT_VALUES: assert property (soft_reset_pulse |-> deglitch_bw == 4'h8 && !drive_override
		&& amp_correction_enable && single_channel_select == 2'h0) else $error("outputs not reset");
	AST_CH3_LEVEL: assert property ((single_channel_select == 2'h3 && !drive_override) [*3] |-> drive_level == 5'h00)
		else $error("channel 3 level not zero");
endmodule // cscd_chk
bind cscd_top cscd_chk i_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .single_channel_select(single_channel_select),
	.scan_wrap(scan_wrap), .drive_level(drive_level), .drive_override(drive_override),
	.amp_correction_enable(amp_correction_enable), .deglitch_bw(deglitch_bw), .soft_reset_pulse(soft_reset_pulse));

// ---- verif/cscd_core.sv ----
`timescale 1ns/1ps
// conversion core and calibration engine seen from the config block
module cscd_core (
	input wire aclk,
	output reg conv_done,
	output reg cal_init_valid,
	output reg amp_corr_valid,
	output reg [1:0] cal_chan,
	output reg [4:0] cal_level
);
	// idle qualifiers start low and the channel and level scrambled so a stale value is never trusted
	initial begin
		conv_done = 1'h0;
		cal_init_valid = 1'h0;
		amp_corr_valid = 1'h0;
		cal_chan = 2'h3;
		cal_level = 5'h1F;
	end
	// finish a conversion after d cycles; long waits model slow settling
	task do_conv(input integer d);
		begin
			repeat (d) @(posedge aclk);
			conv_done <= 1'h1;
			@(posedge aclk);
			conv_done <= 1'h0;
		end
	endtask
	// one-cycle calibration result, then the qualifiers drop and the channel and level are inverted
	task do_cal(input init, input [1:0] ch, input [4:0] lv);
		begin
			@(posedge aclk);
			cal_init_valid <= init;
			amp_corr_valid <= !init;
			cal_chan <= ch;
			cal_level <= lv;
			@(posedge aclk);
			cal_init_valid <= 1'h0;
			amp_corr_valid <= 1'h0;
			cal_chan <= ~ch;
			cal_level <= ~lv;
		end
	endtask
endmodule // cscd_core

// ---- verif/channel_scan_drive_config_test.sv ----
`timescale 1ns/1ps
`include "cscd_regs.vh"
module channel_scan_drive_config_test;
	reg aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg [7:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata;
	reg [3:0] s_axi_wstrb;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_done, cal_init_valid;
	wire amp_corr_valid, scan_wrap, drive_override, amp_correction_enable, soft_reset_pulse;
	wire [1:0] s_axi_bresp, s_axi_rresp, cal_chan, single_channel_select;
	wire [31:0] s_axi_rdata;
	wire [4:0] cal_level, drive_level;
	wire [3:0] deglitch_bw;
	integer err_total, check_count, seed, i, k, n;
	reg [17:0] exp_q [$]; // expected {rresp, rdata} in issue order
	reg [3:0] n_soft; // soft reset pulses seen
	reg [3:0] n_wrap; // scan list restarts seen
	reg [4:0] lv;
	reg [11:0] dgc; // deglitch codes 1, 4, 5, 7
	cscd_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .conv_done(conv_done), .cal_init_valid(cal_init_valid),
		.amp_corr_valid(amp_corr_valid), .cal_chan(cal_chan), .cal_level(cal_level), .single_channel_select(single_channel_select),
		.scan_wrap(scan_wrap), .drive_level(drive_level), .drive_override(drive_override),
		.amp_correction_enable(amp_correction_enable), .deglitch_bw(deglitch_bw), .soft_reset_pulse(soft_reset_pulse));
	cscd_core i_core (.aclk(aclk), .conv_done(conv_done), .cal_init_valid(cal_init_valid),
		.amp_corr_valid(amp_corr_valid), .cal_chan(cal_chan), .cal_level(cal_level));
	initial begin
		aclk = 1'h0;
		forever #2.5 aclk = ~aclk;
	end
	task check(input string nm, input [17:0] seen, input [17:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("wrong value %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d errors %0d", check_count, err_total);
			if (err_total == 0 && check_count > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	// one write, both channels offered together, waits for the response
	task wr(input [5:0] idx, input [15:0] d, input [1:0] er);
		begin
			@(posedge aclk);
			s_axi_awaddr <= {idx, 2'h0};
			s_axi_wdata <= {16'h0000, d};
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			do begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'h0;
				if (s_axi_wready) s_axi_wvalid <= 1'h0;
			end while (s_axi_awvalid || s_axi_wvalid);
			do @(posedge aclk); while (!s_axi_bvalid);
			check("bresp", {16'h0000, s_axi_bresp}, {16'h0000, er});
			s_axi_bready <= 1'h0;
		end
	endtask
	// one read; the watcher compares the data against the note
	task rd(input [5:0] idx, input [17:0] e);
		begin
			@(posedge aclk);
			s_axi_araddr <= {idx, 2'h0};
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			exp_q.push_back(e);
			do @(posedge aclk); while (!s_axi_arready);
			s_axi_arvalid <= 1'h0;
			do @(posedge aclk); while (!s_axi_rvalid);
			s_axi_rready <= 1'h0;
		end
	endtask
	function [15:0] gen(input [1:0] sel, input ovr, input dis);
		gen = 16'h2801 | {sel, 14'h0} | {ovr, 12'h0} | {dis, 10'h0};
	endfunction
	// reserved bits always carry their fixed pattern
	function [15:0] scan(input en, input [1:0] ord, input [2:0] dg);
		scan = {en, ord, 10'h041, dg};
	endfunction
	// read watcher: an empty queue yields an impossible note
	always @(posedge aclk)
		if (s_axi_rvalid && s_axi_rready)
			check("rdata", {s_axi_rresp, s_axi_rdata[15:0]}, (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3FFFF);
	always @(posedge aclk)
		if (soft_reset_pulse === 1'h1) n_soft <= n_soft + 4'h1;
	always @(posedge aclk)
		if (scan_wrap === 1'h1) n_wrap <= n_wrap + 4'h1;
	// watchdog well beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge aclk);
		err_total = err_total + 1;
		report_and_stop;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		ce = 1'h1;
		s_axi_wstrb = 4'hF;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		{err_total, check_count, n_soft, n_wrap} = 0;
		seed = 32'he42f;
		dgc = {3'h7, 3'h5, 3'h4, 3'h1};
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		rd(`CSCD_IDX_GEN_CFG, {2'h0, `CSCD_GEN_CFG_RST});
		rd(`CSCD_IDX_SCAN_CFG, {2'h0, `CSCD_SCAN_CFG_RST});
		rd(`CSCD_IDX_SOFT_RST, 18'h0);
		rd(`CSCD_IDX_DRV2, 18'h0);
		rd(6'h1D, {`CSCD_RESP_SLVERR, 16'h0000});
		wr(6'h1D, 16'hFFFF, `CSCD_RESP_SLVERR);
		// every defined deglitch code against its one-hot bandwidth, widest first
		for (i = 3; i >= 0; i = i - 1) begin
			wr(`CSCD_IDX_SCAN_CFG, scan(1'h0, 2'h0, dgc[3*i +: 3]), `CSCD_RESP_OKAY);
			repeat (2) @(posedge aclk);
			check("deglitch_bw", deglitch_bw, 4'h1 << i);
		end
		// an undefined code falls back to the widest filter
		wr(`CSCD_IDX_SCAN_CFG, scan(1'h0, 2'h0, 3'h2), `CSCD_RESP_OKAY);
		repeat (2) @(posedge aclk);
		check("deglitch_bw", deglitch_bw, 4'h8);
		// single channel stays put through conversions, channel 3 included
		for (i = 0; i < 4; i = i + 1) begin
			wr(`CSCD_IDX_GEN_CFG, gen(i[1:0], 1'h0, 1'h0), `CSCD_RESP_OKAY);
			repeat (4) @(posedge aclk);
			i_core.do_conv(1);
			@(posedge aclk);
			check("single_channel_select", single_channel_select, i[1:0]);
		end
		// every scan list over two passes, random conversion times
		for (i = 0; i < 4; i = i + 1) begin
			n = (i == 3) ? 2 : i + 2;
			wr(`CSCD_IDX_SCAN_CFG, scan(1'h1, i[1:0], 3'h7), `CSCD_RESP_OKAY); // tanks above 10 MHz
			repeat (2) @(posedge aclk);
			check("single_channel_select", single_channel_select, 2'h0);
			for (k = 1; k <= 2 * n; k = k + 1) begin
				i_core.do_conv($random(seed) & 3);
				@(posedge aclk);
				check("single_channel_select", single_channel_select, k % n);
			end
		end
		// channel 1 drive: programmed against calibrated level
		lv = $random(seed);
		wr(`CSCD_IDX_SCAN_CFG, scan(1'h0, 2'h0, 3'h7), `CSCD_RESP_OKAY);
		check("scan_wrap", n_wrap, 4'h8);
		wr(`CSCD_IDX_DRV1, {lv, 11'h7FF}, `CSCD_RESP_OKAY);
		i_core.do_cal(1'h1, 2'h1, 5'h0A);
		// a frozen block must ignore a calibration result
		ce <= 1'h0;
		i_core.do_cal(1'h1, 2'h1, 5'h1F);
		ce <= 1'h1;
		rd(`CSCD_IDX_DRV1, {2'h0, lv, 5'h0A, 6'h00});
		wr(`CSCD_IDX_GEN_CFG, gen(2'h1, 1'h0, 1'h0), `CSCD_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check("drive_level", drive_level, 5'h0A);
		wr(`CSCD_IDX_GEN_CFG, gen(2'h1, 1'h1, 1'h0), `CSCD_RESP_OKAY);
		repeat (3) @(posedge aclk);
		check("drive_level", drive_level, lv);
		check("drive_override", drive_override, 1'h1);
		i_core.do_cal(1'h0, 2'h1, 5'h13);
		rd(`CSCD_IDX_DRV1, {2'h0, lv, 5'h13, 6'h00});
		wr(`CSCD_IDX_GEN_CFG, gen(2'h1, 1'h1, 1'h1), `CSCD_RESP_OKAY);
		repeat (2) @(posedge aclk);
		check("amp_correction_enable", amp_correction_enable, 1'h0);
		i_core.do_cal(1'h0, 2'h1, 5'h04);
		rd(`CSCD_IDX_DRV1, {2'h0, lv, 5'h13, 6'h00});
		// soft reset brings every register back
		wr(`CSCD_IDX_SOFT_RST, 16'h8000, `CSCD_RESP_OKAY);
		repeat (6) @(posedge aclk);
		check("soft_reset_pulse", n_soft, 4'h1);
		rd(`CSCD_IDX_SOFT_RST, 18'h0);
		rd(`CSCD_IDX_GEN_CFG, {2'h0, `CSCD_GEN_CFG_RST});
		rd(`CSCD_IDX_DRV1, 18'h0);
		rd(`CSCD_IDX_SCAN_CFG, {2'h0, `CSCD_SCAN_CFG_RST});
		repeat (2) @(posedge aclk);
		report_and_stop;
	end
endmodule // channel_scan_drive_config_test
